// >>> aux_seq_pkg.sv
// Shared constants and types for the auxiliary converter step sequencer
package aux_seq_pkg;

    // Register indices; the byte address is four times the index
    localparam logic [7:0] IDX_AUX_CTRL      = 8'h01;
    localparam logic [7:0] IDX_CONV_CTRL     = 8'h02;
    localparam logic [7:0] IDX_STATUS        = 8'h03;
    localparam logic [7:0] IDX_RESULT_BASE   = 8'h10;
    localparam logic [7:0] IDX_RESULT_LAST   = 8'h1F;
    localparam logic [7:0] IDX_STEP_CFG_BASE = 8'h8C;
    localparam logic [7:0] IDX_STEP_CFG_LAST = 8'h9B;
    localparam logic [7:0] IDX_SEQ_CFG       = 8'h9C;

    localparam int ADDR_W    = 12;
    localparam int DATA_W    = 32;
    localparam int NUM_STEPS = 16;
    localparam int STEP_W    = 4;
    localparam int RESULT_W  = 16;
    localparam int CFG_W     = 12;
    localparam int CNT_W     = 20;

    // Field positions
    localparam int AUX_EN_BIT     = 0;
    localparam int STANDBY_BIT    = 1;
    localparam int START_BIT      = 0;
    localparam int STOP_BIT       = 1;
    localparam int STAT_RUN_BIT   = 0;
    localparam int STAT_STOP_BIT  = 1;
    localparam int STAT_ARMED_BIT = 2;
    localparam int STAT_STEP_LSB  = 4;
    localparam int SEQ_EN_LSB     = 0;
    localparam int SEQ_DELAY_LSB  = 16;
    localparam int SEQ_MODE_LSB   = 20;

    // Reset values
    localparam logic [15:0]      STEP_EN_RESET  = 16'h0000;
    localparam logic [2:0]       DELAY_RESET    = 3'h0;
    localparam logic [1:0]       MODE_RESET     = 2'h0;
    localparam logic [CFG_W-1:0] STEP_CFG_RESET = 12'h000;
    localparam logic [15:0]      RESULT_CLEAR   = 16'h0000;

    // Default mode encodings
    localparam logic [1:0] MODE_CONT_DEF   = 2'h0;
    localparam logic [1:0] MODE_SINGLE_DEF = 2'h1;
    localparam logic [1:0] MODE_SYNC_DEF   = 2'h2;

    // Timing: settling delay base unit, doubled per delay code
    localparam int CLK_PERIOD_PS      = 5000;
    localparam int SETTLE_UNIT_NS     = 500;
    localparam int SETTLE_UNIT_CYCLES =
        (SETTLE_UNIT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    typedef struct packed {
        logic [3:0] neg;
        logic [3:0] pos;
        logic [3:0] gain;
    } step_cfg_t;

    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_PICK    = 2'b01,
        ST_SETTLE  = 2'b10,
        ST_CONVERT = 2'b11
    } seq_state_t;

    // Lowest enabled step at or above from; 5'h10 when none is left
    function automatic logic [4:0] next_enabled(input logic [15:0] mask,
                                                input logic [4:0]  from);
        logic [4:0] pick;
        pick = 5'h10;
        for (int i = NUM_STEPS - 1; i >= 0; i--)
        begin
            if (mask[i] && (5'(i) >= from))
            begin
                pick = 5'(i);
            end
        end
        return pick;
    endfunction

endpackage

// >>> step_result_mem.sv
// Two-bank result store, one bank shown while the other fills
`timescale 1ns/10ps
module step_result_mem (
    input  wire logic                              pclk,
    input  wire logic                              we,
    input  wire logic [4:0]                        waddr,
    input  wire logic [aux_seq_pkg::RESULT_W-1:0]  wdata,
    input  wire logic [4:0]                        raddr,
    output logic      [aux_seq_pkg::RESULT_W-1:0]  rdata
);

    logic [aux_seq_pkg::RESULT_W-1:0] mem [0:31];

    always_ff @(posedge pclk)
    begin
        if (we)
        begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge pclk)
    begin
        rdata <= mem[raddr];
    end

endmodule

// >>> aux_adc_channel_sequencer.sv
// Auxiliary converter step sequencer with APB register access
//
// Summary of operation
// - Sixteen steps, each enabled by its own bit, one conversion per step.
// - Each step's config sets gain and both mux inputs before converting.
// - Every run starts at step 0, ascending, skipping disabled steps.
// - One global 3-bit settling delay precedes every step's conversion.
// - Run time is enabled steps times one pick cycle plus settling plus conversion time, plus one final pick cycle.
// - Running flag is set exactly while a run is in progress.
// - Start written while converter disabled starts nothing.
// - Per-step 16-bit results at indices 10h to 1Fh, read by software.
// - Disabled step results read 0000h after a run.
// - All results update together at run end; reads never mix runs.
// - Two-bit mode field picks continuous, single-shot or synchronised.
// - Continuous mode repeats runs until stopped.
// - Continuous mode start during a run aborts and restarts it.
// - Stop lets the run finish; stop bit reads 1 until halted in continuous mode only.
// - Disable or standby aborts a run at once.
// - Start and stop in one write: start wins.
// - Results survive stop; cleared only by reset, disable or standby.
// - Single-shot: one run per start, restart on start, stop ignored.
// - Synchronised: main starts trigger runs only while idle.
`timescale 1ns/10ps
module aux_adc_channel_sequencer #(
    parameter logic [1:0] mode_cont          = aux_seq_pkg::MODE_CONT_DEF,
    parameter logic [1:0] mode_single        = aux_seq_pkg::MODE_SINGLE_DEF,
    parameter logic [1:0] mode_sync          = aux_seq_pkg::MODE_SYNC_DEF,
    parameter int         settle_unit_cycles = aux_seq_pkg::SETTLE_UNIT_CYCLES
) (
    input  wire logic                              pclk,
    input  wire logic                              presetn,
    input  wire logic                              psel,
    input  wire logic                              penable,
    input  wire logic                              pwrite,
    input  wire logic [aux_seq_pkg::ADDR_W-1:0]    paddr,
    input  wire logic [aux_seq_pkg::DATA_W-1:0]    pwdata,
    output logic      [aux_seq_pkg::DATA_W-1:0]    prdata,
    output logic                                   pready,
    output logic                                   pslverr,
    output aux_seq_pkg::step_cfg_t                 conv_cfg,
    output logic                                   conv_start,
    output logic                                   conv_abort,
    input  wire logic                              conv_done,
    input  wire logic [aux_seq_pkg::RESULT_W-1:0]  conv_data,
    input  wire logic                              main_conv_start,
    output logic                                   seq_running_flag
);

    logic [7:0]                        idx;
    logic                              addr_ok;
    logic                              wr_go;
    logic                              rd_load;
    logic [aux_seq_pkg::DATA_W-1:0]    rd_mux;
    logic                              aux_conv_enable;
    logic                              standby;
    logic                              conv_on;
    logic [15:0]                       step_enable_bit;
    logic [2:0]                        settle_delay_sel;
    logic [1:0]                        seq_mode_sel;
    logic [aux_seq_pkg::CFG_W-1:0]     step_config_reg [0:15];
    logic                              start_wr;
    logic                              stop_wr;
    logic                              start_go;
    logic                              sync_go;
    logic                              stop_pending;
    logic                              armed;
    aux_seq_pkg::seq_state_t           state;
    aux_seq_pkg::seq_state_t           next_state;
    logic [3:0]                        cur_step;
    logic [4:0]                        scan_from;
    logic [4:0]                        next_step;
    logic                              commit;
    logic [aux_seq_pkg::CNT_W-1:0]     settle_cnt;
    logic                              shown_bank;
    logic [1:0][15:0]                  step_valid;
    logic                              rd_valid;
    logic                              mem_we;
    logic [aux_seq_pkg::RESULT_W-1:0]  mem_q;
    logic                              is_cont;
    logic                              is_sync;

    assign idx     = paddr[9:2];
    assign addr_ok = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0) &&
                     ((idx == aux_seq_pkg::IDX_AUX_CTRL) ||
                      (idx == aux_seq_pkg::IDX_CONV_CTRL) ||
                      (idx == aux_seq_pkg::IDX_STATUS) ||
                      (idx == aux_seq_pkg::IDX_SEQ_CFG) ||
                      ((idx >= aux_seq_pkg::IDX_RESULT_BASE) &&
                       (idx <= aux_seq_pkg::IDX_RESULT_LAST)) ||
                      ((idx >= aux_seq_pkg::IDX_STEP_CFG_BASE) &&
                       (idx <= aux_seq_pkg::IDX_STEP_CFG_LAST)));
    assign wr_go   = psel && penable && pready && pwrite && addr_ok;
    assign rd_load = psel && penable && !pready;

    assign conv_on  = aux_conv_enable && !standby;
    assign is_cont  = (seq_mode_sel == mode_cont);
    assign is_sync  = (seq_mode_sel == mode_sync);
    assign start_wr = wr_go && (idx == aux_seq_pkg::IDX_CONV_CTRL) &&
                      pwdata[aux_seq_pkg::START_BIT];
    assign stop_wr  = wr_go && (idx == aux_seq_pkg::IDX_CONV_CTRL) &&
                      pwdata[aux_seq_pkg::STOP_BIT];
    assign start_go = start_wr && conv_on;
    assign sync_go  = is_sync && armed && (state == aux_seq_pkg::ST_IDLE) &&
                      main_conv_start && conv_on && !start_go;

    // APB answer one cycle into the access phase so read data is flopped
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end
        else
        begin
            pready  <= rd_load;
            pslverr <= rd_load && !addr_ok;
            if (rd_load && !pwrite)
            begin
                prdata <= addr_ok ? rd_mux : 32'h00000000;
            end
        end
    end

    always_comb
    begin
        rd_mux = 32'h00000000;
        if ((idx >= aux_seq_pkg::IDX_RESULT_BASE) &&
            (idx <= aux_seq_pkg::IDX_RESULT_LAST))
        begin
            rd_mux[15:0] = rd_valid ? mem_q : aux_seq_pkg::RESULT_CLEAR;
        end
        else if ((idx >= aux_seq_pkg::IDX_STEP_CFG_BASE) &&
                 (idx <= aux_seq_pkg::IDX_STEP_CFG_LAST))
        begin
            rd_mux[aux_seq_pkg::CFG_W-1:0] =
                step_config_reg[4'(idx - aux_seq_pkg::IDX_STEP_CFG_BASE)];
        end
        else
        begin
            case (idx)
                aux_seq_pkg::IDX_AUX_CTRL:
                begin
                    rd_mux[aux_seq_pkg::AUX_EN_BIT]  = aux_conv_enable;
                    rd_mux[aux_seq_pkg::STANDBY_BIT] = standby;
                end
                aux_seq_pkg::IDX_CONV_CTRL:
                    rd_mux[aux_seq_pkg::STOP_BIT] = stop_pending;
                aux_seq_pkg::IDX_STATUS:
                begin
                    rd_mux[aux_seq_pkg::STAT_RUN_BIT]   = seq_running_flag;
                    rd_mux[aux_seq_pkg::STAT_STOP_BIT]  = stop_pending;
                    rd_mux[aux_seq_pkg::STAT_ARMED_BIT] = armed;
                    rd_mux[aux_seq_pkg::STAT_STEP_LSB +: 4] = cur_step;
                end
                aux_seq_pkg::IDX_SEQ_CFG:
                begin
                    rd_mux[aux_seq_pkg::SEQ_EN_LSB +: 16]  = step_enable_bit;
                    rd_mux[aux_seq_pkg::SEQ_DELAY_LSB +: 3] = settle_delay_sel;
                    rd_mux[aux_seq_pkg::SEQ_MODE_LSB +: 2]  = seq_mode_sel;
                end
                default:
                    rd_mux = 32'h00000000;
            endcase
        end
    end

    // Configuration is taken as written; the host keeps it still while on
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            aux_conv_enable  <= 1'b0;
            standby          <= 1'b0;
            step_enable_bit  <= aux_seq_pkg::STEP_EN_RESET;
            settle_delay_sel <= aux_seq_pkg::DELAY_RESET;
            seq_mode_sel     <= aux_seq_pkg::MODE_RESET;
            for (int i = 0; i < aux_seq_pkg::NUM_STEPS; i++)
            begin
                step_config_reg[i] <= aux_seq_pkg::STEP_CFG_RESET;
            end
        end
        else if (wr_go)
        begin
            if (idx == aux_seq_pkg::IDX_AUX_CTRL)
            begin
                aux_conv_enable <= pwdata[aux_seq_pkg::AUX_EN_BIT];
                standby         <= pwdata[aux_seq_pkg::STANDBY_BIT];
            end
            else if (idx == aux_seq_pkg::IDX_SEQ_CFG)
            begin
                step_enable_bit  <= pwdata[aux_seq_pkg::SEQ_EN_LSB +: 16];
                settle_delay_sel <= pwdata[aux_seq_pkg::SEQ_DELAY_LSB +: 3];
                seq_mode_sel     <= pwdata[aux_seq_pkg::SEQ_MODE_LSB +: 2];
            end
            else if ((idx >= aux_seq_pkg::IDX_STEP_CFG_BASE) &&
                     (idx <= aux_seq_pkg::IDX_STEP_CFG_LAST))
            begin
                step_config_reg[4'(idx - aux_seq_pkg::IDX_STEP_CFG_BASE)] <=
                    pwdata[aux_seq_pkg::CFG_W-1:0];
            end
        end
    end

    assign next_step = aux_seq_pkg::next_enabled(step_enable_bit, scan_from);
    assign commit    = (state == aux_seq_pkg::ST_PICK) && next_step[4];

    always_comb
    begin
        next_state = state;
        if (!conv_on)
        begin
            next_state = aux_seq_pkg::ST_IDLE;
        end
        else if (start_go || sync_go)
        begin
            next_state = aux_seq_pkg::ST_PICK;
        end
        else
        begin
            case (state)
                aux_seq_pkg::ST_IDLE:
                    next_state = aux_seq_pkg::ST_IDLE;
                aux_seq_pkg::ST_PICK:
                    if (!next_step[4])
                        next_state = aux_seq_pkg::ST_SETTLE;
                    else if (is_cont && !stop_pending)
                        next_state = aux_seq_pkg::ST_PICK;
                    else
                        next_state = aux_seq_pkg::ST_IDLE;
                aux_seq_pkg::ST_SETTLE:
                    if (settle_cnt == 20'h00001)
                        next_state = aux_seq_pkg::ST_CONVERT;
                aux_seq_pkg::ST_CONVERT:
                    if (conv_done)
                        next_state = aux_seq_pkg::ST_PICK;
                default:
                    next_state = aux_seq_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state            <= aux_seq_pkg::ST_IDLE;
            seq_running_flag <= 1'b0;
        end
        else
        begin
            state            <= next_state;
            seq_running_flag <= (next_state != aux_seq_pkg::ST_IDLE);
        end
    end

    localparam logic [aux_seq_pkg::CNT_W-1:0] CNT_ONE_LOAD =
        aux_seq_pkg::CNT_W'(settle_unit_cycles);

    // Step walk, settling count and converter drive
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            scan_from  <= 5'h00;
            cur_step   <= 4'h0;
            settle_cnt <= 20'h00000;
            conv_cfg   <= '0;
            conv_start <= 1'b0;
            conv_abort <= 1'b0;
        end
        else
        begin
            conv_start <= 1'b0;
            conv_abort <= ((state == aux_seq_pkg::ST_SETTLE) ||
                           (state == aux_seq_pkg::ST_CONVERT)) &&
                          (!conv_on || start_go);
            if (start_go || sync_go)
            begin
                scan_from <= 5'h00;
            end
            else if (state == aux_seq_pkg::ST_PICK)
            begin
                if (next_step[4])
                begin
                    scan_from <= 5'h00;
                end
                else
                begin
                    cur_step   <= next_step[3:0];
                    conv_cfg   <= step_config_reg[next_step[3:0]];
                    settle_cnt <= CNT_ONE_LOAD << settle_delay_sel;
                end
            end
            else if (state == aux_seq_pkg::ST_SETTLE)
            begin
                settle_cnt <= settle_cnt - 20'h00001;
                conv_start <= conv_on && (settle_cnt == 20'h00001);
            end
            else if ((state == aux_seq_pkg::ST_CONVERT) && conv_done)
            begin
                scan_from <= 5'({1'b0, cur_step} + 5'h01);
            end
        end
    end

    // Stop request and synchronised-mode arming
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            stop_pending <= 1'b0;
            armed        <= 1'b0;
        end
        else
        begin
            if (!conv_on || start_go)
                stop_pending <= 1'b0;
            // A stop racing the halting run end must not stick
            else if (stop_wr && is_cont &&
                     (next_state != aux_seq_pkg::ST_IDLE))
                stop_pending <= 1'b1;
            else if (commit)
                stop_pending <= 1'b0;
            if (!conv_on)
                armed <= 1'b0;
            else if (start_go)
                armed <= is_sync;
            else if (stop_wr && is_sync)
                armed <= 1'b0;
        end
    end

    // Results fill the hidden bank; the banks swap only at run end
    assign mem_we = (state == aux_seq_pkg::ST_CONVERT) && conv_done &&
                    conv_on && !start_go;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            shown_bank <= 1'b0;
            step_valid <= '0;
            rd_valid   <= 1'b0;
        end
        else
        begin
            rd_valid <= step_valid[shown_bank][idx[3:0]];
            if (!conv_on)
                step_valid <= '0;
            else if (start_go || sync_go)
                step_valid[~shown_bank] <= 16'h0000;
            else if (commit)
            begin
                shown_bank             <= ~shown_bank;
                step_valid[shown_bank] <= 16'h0000;
            end
            else if (mem_we)
                step_valid[~shown_bank][cur_step] <= 1'b1;
        end
    end

    step_result_mem u_results (
        .pclk  (pclk),
        .we    (mem_we),
        .waddr ({~shown_bank, cur_step}),
        .wdata (conv_data),
        .raddr ({shown_bank, idx[3:0]}),
        .rdata (mem_q)
    );

    property p_start_runs;
        @(posedge pclk) disable iff (!presetn)
        start_go |=> seq_running_flag && (state == aux_seq_pkg::ST_PICK);
    endproperty
    a_start_runs: assert property (p_start_runs)
        else $error("accepted start did not raise the running flag");

    property p_start_disabled;
        @(posedge pclk) disable iff (!presetn)
        (start_wr && !conv_on) |=> !seq_running_flag;
    endproperty
    a_start_disabled: assert property (p_start_disabled)
        else $error("start while disabled began a run");

    property p_abort_now;
        @(posedge pclk) disable iff (!presetn)
        $fell(conv_on) |=> !seq_running_flag && (step_valid == '0);
    endproperty
    a_abort_now: assert property (p_abort_now)
        else $error("disable did not abort the run and clear results");

    property p_settle_first;
        @(posedge pclk) disable iff (!presetn)
        conv_start |-> $past(state, 1) == aux_seq_pkg::ST_SETTLE &&
                       step_enable_bit[cur_step];
    endproperty
    a_settle_first: assert property (p_settle_first)
        else $error("conversion started without settling on an enabled step");

    property p_stop_clears;
        @(posedge pclk) disable iff (!presetn)
        !seq_running_flag |-> ##1 !stop_pending;
    endproperty
    a_stop_clears: assert property (p_stop_clears)
        else $error("stop bit still set after the sequencer halted");

    property p_single_once;
        @(posedge pclk) disable iff (!presetn)
        (commit && seq_mode_sel == mode_single && !start_go && conv_on)
            |=> !seq_running_flag;
    endproperty
    a_single_once: assert property (p_single_once)
        else $error("single-shot run repeated");

    property p_sync_trigger;
        @(posedge pclk) disable iff (!presetn)
        sync_go |=> seq_running_flag && (state == aux_seq_pkg::ST_PICK);
    endproperty
    a_sync_trigger: assert property (p_sync_trigger)
        else $error("main start did not trigger a synchronised run");

    property p_bank_swap;
        @(posedge pclk) disable iff (!presetn)
        $changed(shown_bank) |-> $past(commit, 1);
    endproperty
    a_bank_swap: assert property (p_bank_swap)
        else $error("result bank changed outside a run completion");

endmodule

// >>> conv_model.sv
// Behavioural auxiliary converter answering start pulses after a latency
`timescale 1ns/10ps
module conv_model (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  conv_start,
    input  wire logic                  conv_abort,
    input  wire aux_seq_pkg::step_cfg_t cfg,
    input  wire logic [3:0]            lat,
    output logic                       conv_done,
    output logic [15:0]                conv_data
);
    logic [4:0] cnt;
    // Data toggles outside the done cycle so no stale value passes
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt       <= 5'h00;
            conv_done <= 1'b0;
            conv_data <= 16'hFFFF;
        end
        else
        begin
            conv_done <= 1'b0;
            conv_data <= ~conv_data;
            if (conv_start)
                cnt <= {1'b0, lat} + 5'h01;
            else if (conv_abort)
                cnt <= 5'h00;
            else if (cnt == 5'h01)
            begin
                conv_done <= 1'b1;
                conv_data <= {4'hA, cfg};
                cnt       <= 5'h00;
            end
            else if (cnt != 5'h00)
                cnt <= cnt - 5'h01;
        end
    end
endmodule

// >>> aux_adc_channel_sequencer_tb.sv
// Self-checking bench for the step sequencer
`timescale 1ns/10ps
module aux_adc_channel_sequencer_tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic conv_start, conv_abort, conv_done, main_conv_start, run;
    logic [15:0] conv_data, mask;
    logic [3:0]  lat;
    logic [11:0] cfg [16];
    aux_seq_pkg::step_cfg_t conv_cfg;
    int fail_count, n_checks, cyc;

    aux_adc_channel_sequencer #(.settle_unit_cycles(2)) DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .conv_cfg(conv_cfg),
        .conv_start(conv_start), .conv_abort(conv_abort),
        .conv_done(conv_done), .conv_data(conv_data),
        .main_conv_start(main_conv_start), .seq_running_flag(run));
    conv_model cm (.pclk(pclk), .presetn(presetn), .conv_start(conv_start),
        .conv_abort(conv_abort), .cfg(conv_cfg), .lat(lat),
        .conv_done(conv_done), .conv_data(conv_data));

    initial
    begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Holds the request until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] idx,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w;
        paddr <= {2'h0, idx, 2'h0}; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        psel <= 1'b0; penable <= 1'b0;
    endtask

    function automatic logic [31:0] expect_res(input int k);
        return mask[k] ? {20'h0000A, cfg[k]} : 32'h0;
    endfunction

    task automatic wait_idle();
        for (int i = 0; i < 4000 && run !== 1'b0; i++) @(posedge pclk);
    endtask

    always @(posedge pclk)
    begin
        cyc++;
        lat <= 4'($urandom);
        if (cyc > 60000)
        begin
            fail_count++;
            close_out();
        end
    end

    initial
    begin
        {psel, penable, pwrite, main_conv_start} = 4'h0;
        paddr = 12'h000; pwdata = 32'h0; presetn = 1'b0;
        fail_count = 0; n_checks = 0;
        void'($urandom(32'hC67F));
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, aux_seq_pkg::IDX_RESULT_BASE, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        chk({31'h0, pslverr}, 32'h1);
        $display("test reset done");
        for (int m = 0; m < 3; m++)
        begin
            apb(1'b1, aux_seq_pkg::IDX_AUX_CTRL, 32'h0);
            mask = 16'($urandom) | 16'h8001;
            for (int k = 0; k < 16; k++)
            begin
                cfg[k] = 12'($urandom);
                apb(1'b1, aux_seq_pkg::IDX_STEP_CFG_BASE + 8'(k), 32'(cfg[k]));
            end
            apb(1'b1, aux_seq_pkg::IDX_SEQ_CFG, {10'h0,
                ((m == 0) ? aux_seq_pkg::MODE_SINGLE_DEF :
                 (m == 1) ? aux_seq_pkg::MODE_CONT_DEF :
                 aux_seq_pkg::MODE_SYNC_DEF), 1'b0, 3'(m), mask});
            apb(1'b1, aux_seq_pkg::IDX_AUX_CTRL, 32'h1);
            apb(1'b1, aux_seq_pkg::IDX_CONV_CTRL, (m == 1) ? 32'h3 : 32'h1);
            @(posedge pclk);
            chk(32'(run), 32'h1);
            if (m != 2)
            begin
                apb(1'b1, aux_seq_pkg::IDX_CONV_CTRL, 32'h2);
                apb(1'b0, aux_seq_pkg::IDX_CONV_CTRL, 32'h0);
                chk(rd & 32'h2, (m == 1) ? 32'h2 : 32'h0);
                // First run still going: cleared old results must show
                apb(1'b0, aux_seq_pkg::IDX_RESULT_BASE, 32'h0);
                chk(rd, 32'h0);
            end
            else
            begin
                wait_idle();
                main_conv_start <= 1'b1;
                @(posedge pclk);
                main_conv_start <= 1'b0;
                @(posedge pclk);
                chk(32'(run), 32'h1);
            end
            wait_idle();
            repeat (200) @(posedge pclk);
            chk(32'(run), 32'h0);
            for (int k = 0; k < 16; k++)
            begin
                apb(1'b0, aux_seq_pkg::IDX_RESULT_BASE + 8'(k), 32'h0);
                chk(rd, expect_res(k));
            end
            $display("test mode %0d done", m);
        end
        apb(1'b1, aux_seq_pkg::IDX_CONV_CTRL, 32'h1);
        apb(1'b1, aux_seq_pkg::IDX_AUX_CTRL, 32'h0);
        repeat (2) @(posedge pclk);
        chk(32'(run), 32'h0);
        apb(1'b1, aux_seq_pkg::IDX_CONV_CTRL, 32'h1);
        repeat (4) @(posedge pclk);
        chk(32'(run), 32'h0);
        apb(1'b0, aux_seq_pkg::IDX_RESULT_BASE + 8'hF, 32'h0);
        chk(rd, 32'h0);
        $display("test abort and disabled start done");
        close_out();
    end
endmodule
